// ==== hdl/fsw_regs.svh ====
`ifndef FSW_REGS_SVH
`define FSW_REGS_SVH
// status word field positions
`define FSW_INVALID_BIT 0
`define FSW_DENORMAL_BIT 1
`define FSW_DIVZERO_BIT 2
`define FSW_OVERFLOW_BIT 3
`define FSW_UNDERFLOW_BIT 4
`define FSW_INEXACT_BIT 5
`define FSW_STACK_FAULT_BIT 6
`define FSW_SUMMARY_BIT 7
`define FSW_COND0_BIT 8
`define FSW_COND1_BIT 9
`define FSW_COND2_BIT 10
`define FSW_TOP_LSB 11
`define FSW_TOP_MSB 13
`define FSW_COND3_BIT 14
`define FSW_BUSY_MIRROR_BIT 15
`define FSW_NUM_EXC 6
`define FSW_RESET_VALUE 16'h0000
`endif

// ==== hdl/fsw_pkg.sv ====
`default_nettype none
package fsw_pkg;
   // instruction classes reported by the pipeline at completion
   typedef enum logic [3:0] {
      CLASS_NONE = 4'h0,
      CLASS_COMPARE = 4'h1,
      CLASS_COMPARE_INT = 4'h2,
      CLASS_EXAMINE = 4'h3,
      CLASS_PREM = 4'h4,
      CLASS_ARITH = 4'h5,
      CLASS_TRIG = 4'h6,
      CLASS_LOAD = 4'h7,
      CLASS_RESTORE = 4'h8,
      CLASS_MISC = 4'h9,
      CLASS_INIT = 4'ha,
      CLASS_CLEAR_EXC = 4'hb
   } instr_class_t;

   typedef struct packed {
      logic [2:0] cond_hi;   // cond_bit_three, cond_bit_two, cond_bit_zero
      logic cond_bit_one;
      logic stack_fault_flag;
      logic [5:0] exc_flags;
      logic [2:0] top;
   } fsw_state_t;
endpackage
`default_nettype wire

// ==== hdl/fsw_cond_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// condition-code proposal from the decoder to the status register
interface fsw_cond_if;
   logic write_hi;
   logic [2:0] cond_hi;
   logic write_one;
   logic cond_one;
   modport decoder (output write_hi, output cond_hi, output write_one, output cond_one);
   modport status (input write_hi, input cond_hi, input write_one, input cond_one);
endinterface
`default_nettype wire

// ==== hdl/fsw_cond_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fsw_regs.svh"
module fsw_cond_decode (
   input wire fsw_pkg::instr_class_t iclass_in,
   input wire logic [2:0] cmp_code_in,
   input wire logic sign_in,
   input wire logic [2:0] class_code_in,
   input wire logic prem_incomplete_in,
   input wire logic [2:0] quotient_in,
   input wire logic range_exceeded_in,
   input wire logic round_up_in,
   input wire logic inexact_in,
   input wire logic stack_fault_in,
   input wire logic stack_overflow_in,
   input wire logic [3:0] image_cond_in,
   fsw_cond_if.decoder cif
);
   // cond_bit_one for classes that report rounding or a stack fault
   function automatic logic round_or_fault(input logic sf, input logic ovf,
                                           input logic ru, input logic px);
      if (sf) begin
         round_or_fault = ovf;
      end else begin
         round_or_fault = px & ru;
      end
   endfunction

   always_comb begin
      cif.write_hi = 1'b0;
      cif.cond_hi = 3'h0;
      cif.write_one = 1'b0;
      cif.cond_one = 1'b0;
      // undefined bits keep their old value: write strobe stays low
      case (iclass_in)
         fsw_pkg::CLASS_COMPARE: begin
            cif.write_hi = 1'b1;
            cif.cond_hi = cmp_code_in;
            cif.write_one = 1'b1;
            cif.cond_one = stack_fault_in & stack_overflow_in;
         end
         fsw_pkg::CLASS_EXAMINE: begin
            cif.write_hi = 1'b1;
            cif.cond_hi = class_code_in;
            cif.write_one = 1'b1;
            cif.cond_one = sign_in;
         end
         fsw_pkg::CLASS_PREM: begin
            cif.write_hi = 1'b1;
            // order is {three, two, zero}: quotient mid, incomplete, quotient high
            cif.cond_hi = {quotient_in[1], prem_incomplete_in, quotient_in[2]};
            cif.write_one = 1'b1;
            cif.cond_one = stack_fault_in ? stack_overflow_in : quotient_in[0];
         end
         fsw_pkg::CLASS_ARITH: begin
            cif.write_one = 1'b1;
            cif.cond_one = round_or_fault(stack_fault_in, stack_overflow_in,
                                          round_up_in, inexact_in);
         end
         fsw_pkg::CLASS_TRIG: begin
            cif.write_hi = 1'b1;
            cif.cond_hi = 3'h0;
            cif.cond_hi[1] = range_exceeded_in;
            cif.write_one = 1'b1;
            cif.cond_one = round_or_fault(stack_fault_in, stack_overflow_in,
                                          round_up_in, inexact_in);
         end
         fsw_pkg::CLASS_LOAD: begin
            cif.write_one = 1'b1;
            cif.cond_one = stack_fault_in & stack_overflow_in;
         end
         fsw_pkg::CLASS_RESTORE: begin
            cif.write_hi = 1'b1;
            cif.cond_hi = {image_cond_in[3], image_cond_in[2], image_cond_in[0]};
            cif.write_one = 1'b1;
            cif.cond_one = image_cond_in[1];
         end
         fsw_pkg::CLASS_INIT: begin
            cif.write_hi = 1'b1;
            cif.write_one = 1'b1;
         end
         default: begin
            cif.write_hi = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// ==== hdl/fsw_status_update.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fsw_regs.svh"
// Behaviour
// - with invalid and stack fault set, cond one is 1 overflow, 0 underflow
// - inexact result with upward final rounding sets cond one to 1
// - examine writes operand sign to cond one and class to others
// - partial remainder sets cond two when incomplete, clears when complete
// - completed remainder loads quotient bits 2,1,0 into cond 0,3,1
// - trig instructions set cond two when source exceeds two to the 63rd
// - six sticky exception flags held in status bits 0 to 5
// - summary bit 7 set by any unmasked flag; masked flags still set
// - flags stay until clear, init or restore overwrite
// - bit 15 always mirrors the summary bit
// - compare writes outcome to cond 0,2,3; cond one 0 unless fault
// - integer-flag compares leave all condition bits undefined
// - arithmetic leaves 0,2,3 undefined; cond one rounding or fault
// - load-type instructions: cond one is 0 unless stack fault
// - environment or state restore loads condition bits from the image
// - misc instructions leave bits undefined; init clears them
// - stack fault flag bit 6 set on overflow or underflow, cleared only by init, clear or restore
// - stack fault flag stays set until init, clear or restore
// - top-of-stack pointer kept in status bits 11 to 13
// - control-word mask bits 0 to 5 gate the summary bit
module fsw_status_update (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic complete_in,
   input wire fsw_pkg::instr_class_t iclass_in,
   input wire logic [5:0] exc_detect_in,
   input wire logic stack_fault_in,
   input wire logic stack_overflow_in,
   input wire logic round_up_in,
   input wire logic [2:0] cmp_code_in,
   input wire logic sign_in,
   input wire logic [2:0] class_code_in,
   input wire logic prem_incomplete_in,
   input wire logic [2:0] quotient_in,
   input wire logic range_exceeded_in,
   input wire logic [15:0] image_in,
   input wire logic top_write_in,
   input wire logic [2:0] top_in,
   input wire logic [5:0] ctrl_mask_in,
   output logic [15:0] fpu_status_word_out
);
   fsw_pkg::fsw_state_t state;
   fsw_pkg::fsw_state_t next_state;
   logic [15:0] next_word;
   logic next_summary;
   fsw_cond_if cif ();
   logic done_fault;

   assign done_fault = complete_in & stack_fault_in;

   fsw_cond_decode decode_i (
      .iclass_in(complete_in ? iclass_in : fsw_pkg::CLASS_NONE),
      .cmp_code_in(cmp_code_in),
      .sign_in(sign_in),
      .class_code_in(class_code_in),
      .prem_incomplete_in(prem_incomplete_in),
      .quotient_in(quotient_in),
      .range_exceeded_in(range_exceeded_in),
      .round_up_in(round_up_in),
      .inexact_in(exc_detect_in[`FSW_INEXACT_BIT]),
      .stack_fault_in(stack_fault_in),
      .stack_overflow_in(stack_overflow_in),
      .image_cond_in({image_in[`FSW_COND3_BIT], image_in[`FSW_COND2_BIT],
                      image_in[`FSW_COND1_BIT], image_in[`FSW_COND0_BIT]}),
      .cif(cif)
   );

   always_comb begin
      next_state = state;
      if (complete_in) begin
         case (iclass_in)
            fsw_pkg::CLASS_INIT, fsw_pkg::CLASS_CLEAR_EXC: begin
               next_state.exc_flags = 6'h00;
               next_state.stack_fault_flag = 1'b0;
            end
            fsw_pkg::CLASS_RESTORE: begin
               next_state.exc_flags = image_in[5:0];
               next_state.stack_fault_flag = image_in[`FSW_STACK_FAULT_BIT];
            end
            default: begin
               next_state.exc_flags = state.exc_flags | exc_detect_in;
               // a stack fault is an invalid operation too
               if (stack_fault_in) begin
                  next_state.exc_flags[`FSW_INVALID_BIT] = 1'b1;
               end
               // set only here and by restore from the image: invalid-operand alone leaves it alone
               next_state.stack_fault_flag = state.stack_fault_flag | done_fault;
            end
         endcase
         if (iclass_in == fsw_pkg::CLASS_INIT) begin
            next_state.top = 3'h0;
         end else if (iclass_in == fsw_pkg::CLASS_RESTORE) begin
            next_state.top = image_in[`FSW_TOP_MSB:`FSW_TOP_LSB];
         end
      end
      if (top_write_in) begin
         next_state.top = top_in;
      end
      if (cif.write_hi) begin
         next_state.cond_hi = cif.cond_hi;
      end
      if (cif.write_one) begin
         next_state.cond_bit_one = cif.cond_one;
      end
      next_summary = |(next_state.exc_flags & ~ctrl_mask_in);
      next_word = `FSW_RESET_VALUE;
      next_word[5:0] = next_state.exc_flags;
      next_word[`FSW_STACK_FAULT_BIT] = next_state.stack_fault_flag;
      next_word[`FSW_SUMMARY_BIT] = next_summary;
      next_word[`FSW_COND0_BIT] = next_state.cond_hi[0];
      next_word[`FSW_COND1_BIT] = next_state.cond_bit_one;
      next_word[`FSW_COND2_BIT] = next_state.cond_hi[1];
      next_word[`FSW_TOP_MSB:`FSW_TOP_LSB] = next_state.top;
      next_word[`FSW_COND3_BIT] = next_state.cond_hi[2];
      next_word[`FSW_BUSY_MIRROR_BIT] = next_summary;
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state <= '0;
         fpu_status_word_out <= `FSW_RESET_VALUE;
      end else begin
         state <= next_state;
         fpu_status_word_out <= next_word;
      end
   end
endmodule
`default_nettype wire

// ==== sim/fsw_status_update_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module fsw_status_update_checker (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic complete_in,
   input wire fsw_pkg::instr_class_t iclass_in,
   input wire logic [5:0] exc_detect_in,
   input wire logic stack_fault_in,
   input wire logic stack_overflow_in,
   input wire logic [2:0] cmp_code_in,
   input wire logic prem_incomplete_in,
   input wire logic [2:0] quotient_in,
   input wire logic [15:0] image_in,
   input wire logic top_write_in,
   input wire logic [2:0] top_in,
   input wire logic [5:0] ctrl_mask_in,
   input wire logic [15:0] fpu_status_word_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   logic [15:0] w;
   logic keep;
   assign w = fpu_status_word_out;
   // only init, clear and restore may drop sticky flags
   assign keep = !(complete_in && (iclass_in == fsw_pkg::CLASS_INIT
      || iclass_in == fsw_pkg::CLASS_CLEAR_EXC || iclass_in == fsw_pkg::CLASS_RESTORE));
   property p_mirror; w[15] == w[7]; endproperty
   property p_summary; w[7] == |(w[5:0] & ~$past(ctrl_mask_in)); endproperty
   property p_sticky; keep |=> (w[6:0] & $past(w[6:0])) == $past(w[6:0]); endproperty
   property p_flags;
      complete_in && keep |=> ((w[5:0] & $past(exc_detect_in)) == $past(exc_detect_in))
         && (w[6] || !$past(stack_fault_in));
   endproperty
   property p_init;
      complete_in && iclass_in == fsw_pkg::CLASS_INIT && !top_write_in |=> w == 16'h0000;
   endproperty
   property p_compare;
      complete_in && iclass_in == fsw_pkg::CLASS_COMPARE |=> {w[14], w[10], w[8], w[9]}
         == {$past(cmp_code_in), $past(stack_fault_in && stack_overflow_in)};
   endproperty
   property p_prem;
      complete_in && iclass_in == fsw_pkg::CLASS_PREM && !prem_incomplete_in
         |=> {w[10], w[8], w[14], w[9]} == {1'b0, $past(quotient_in[2:1]),
         $past(stack_fault_in ? stack_overflow_in : quotient_in[0])};
   endproperty
   property p_restore;
      complete_in && iclass_in == fsw_pkg::CLASS_RESTORE && !top_write_in
         |=> {w[14:8], w[6:0]} == {$past(image_in[14:8]), $past(image_in[6:0])};
   endproperty
   property p_top; top_write_in |=> w[13:11] == $past(top_in); endproperty
   property p_hold; !complete_in && !top_write_in |=> $stable({w[14:8], w[6:0]}); endproperty
   a_mirror: assert property (p_mirror) else $error("mirror bit off");
   a_summary: assert property (p_summary) else $error("summary bit off");
   a_sticky: assert property (p_sticky) else $error("sticky flag lost");
   a_flags: assert property (p_flags) else $error("flag not set");
   a_init: assert property (p_init) else $error("init not cleared");
   a_compare: assert property (p_compare) else $error("compare code off");
   a_prem: assert property (p_prem) else $error("remainder code off");
   a_restore: assert property (p_restore) else $error("restore off");
   a_top: assert property (p_top) else $error("top not loaded");
   a_hold: assert property (p_hold) else $error("word moved when idle");
   c_compare: cover property (complete_in && iclass_in == fsw_pkg::CLASS_COMPARE);
   c_prem: cover property (complete_in && iclass_in == fsw_pkg::CLASS_PREM);
   c_restore: cover property (complete_in && iclass_in == fsw_pkg::CLASS_RESTORE);
endmodule
bind fsw_status_update fsw_status_update_checker u_chk (.mclk_in(mclk_in),
   .rst_n_in(rst_n_in), .complete_in(complete_in), .iclass_in(iclass_in),
   .exc_detect_in(exc_detect_in), .stack_fault_in(stack_fault_in),
   .stack_overflow_in(stack_overflow_in), .cmp_code_in(cmp_code_in),
   .prem_incomplete_in(prem_incomplete_in), .quotient_in(quotient_in), .image_in(image_in),
   .top_write_in(top_write_in), .top_in(top_in), .ctrl_mask_in(ctrl_mask_in),
   .fpu_status_word_out(fpu_status_word_out));
`default_nettype wire

// ==== sim/fsw_pipe_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// execution pipeline: unpacks one completion record per cycle
module fsw_pipe_model (
   input wire logic [55:0] op_in,
   output logic complete_out,
   output fsw_pkg::instr_class_t iclass_out,
   output logic [5:0] exc_out,
   output logic fault_out,
   output logic ovf_out,
   output logic [15:0] rest_out,
   output logic tw_out,
   output logic [2:0] top_out,
   output logic [5:0] mask_out,
   output logic [15:0] image_out
);
   assign complete_out = op_in[0] | op_in[1];
   // codes c..f fold onto 4..7 so every class stays legal
   assign iclass_out = fsw_pkg::instr_class_t'(op_in[5] & op_in[4] ? {1'b0, op_in[4:2]}
                                                                   : op_in[5:2]);
   // exceptions kept sparse so the sticky bits do not saturate at once
   assign exc_out = op_in[11:6] & {6{op_in[12]}};
   assign fault_out = op_in[13] & op_in[14];
   assign ovf_out = op_in[15];
   assign rest_out = {3'h0, op_in[28:16]};
   assign tw_out = op_in[29] & op_in[30];
   assign {top_out, mask_out, image_out} = op_in[55:31];
endmodule
`default_nettype wire

// ==== sim/test_fsw_status_update.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_fsw_status_update;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [55:0] op = 56'h0;
   logic [31:0] seed = 32'h00000026;
   logic [15:0] exp_w = 16'h0000;
   logic [15:0] care = 16'hffff;
   logic [15:0] word, rest, img;
   int failures = 0;
   int checks_done = 0;
   logic cpl, flt, ovf, tw;
   fsw_pkg::instr_class_t ic;
   logic [5:0] exc, msk;
   logic [2:0] top;
   fsw_pipe_model u_pipe (.op_in(op), .complete_out(cpl), .iclass_out(ic), .exc_out(exc),
      .fault_out(flt), .ovf_out(ovf), .rest_out(rest), .tw_out(tw), .top_out(top),
      .mask_out(msk), .image_out(img));
   fsw_status_update u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .complete_in(cpl),
      .iclass_in(ic), .exc_detect_in(exc), .stack_fault_in(flt), .stack_overflow_in(ovf),
      .round_up_in(rest[0]), .cmp_code_in(rest[3:1]), .sign_in(rest[4]),
      .class_code_in(rest[7:5]), .prem_incomplete_in(rest[8]), .quotient_in(rest[11:9]),
      .range_exceeded_in(rest[12]), .image_in(img), .top_write_in(tw), .top_in(top),
      .ctrl_mask_in(msk), .fpu_status_word_out(word));
   initial forever #5 mclk_in = ~mclk_in;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [15:0] nxt(input logic [15:0] w);
      logic [15:0] n;
      logic ru;
      n = w;
      ru = flt ? ovf : (exc[5] & rest[0]);
      if (cpl) begin
         n[6:0] = n[6:0] | {flt, exc[5:1], exc[0] | flt};
         case (ic)
            fsw_pkg::CLASS_COMPARE: {n[14], n[10], n[8], n[9]} = {rest[3:1], flt & ovf};
            fsw_pkg::CLASS_EXAMINE: {n[14], n[10], n[8], n[9]} = {rest[7:5], rest[4]};
            fsw_pkg::CLASS_PREM: begin
               // quotient bits are loaded on every remainder step, complete or not
               {n[14], n[10], n[8], n[9]} = {rest[10], rest[8], rest[11], rest[9]};
               if (flt) n[9] = ovf;
            end
            fsw_pkg::CLASS_ARITH: n[9] = ru;
            fsw_pkg::CLASS_TRIG: {n[14], n[10], n[8], n[9]} = {1'b0, rest[12], 1'b0, ru};
            fsw_pkg::CLASS_LOAD: n[9] = flt & ovf;
            fsw_pkg::CLASS_RESTORE: n = {1'b0, img[14:8], 1'b0, img[6:0]};
            fsw_pkg::CLASS_INIT: n = 16'h0000;
            fsw_pkg::CLASS_CLEAR_EXC: n[6:0] = 7'h00;
            default: ;
         endcase
      end
      if (tw) n[13:11] = top;
      n[7] = |(n[5:0] & ~msk);
      n[15] = n[7];
      return n;
   endfunction
   task automatic cmp_word();
      checks_done++;
      if ((word & care) !== (exp_w & care)) begin
         failures++;
         $display("[ERR] %0t word %h expected %h", $time, word, exp_w);
      end
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic step(input int i, input logic directed);
      logic [55:0] d;
      @(posedge mclk_in);
      seed = xs(seed);
      d[31:0] = seed;
      seed = xs(seed);
      d[55:32] = seed[23:0];
      // directed pass walks every class code once with a completion
      if (directed) d[5:0] = {i[3:0], 2'b11};
      op <= d;
      #1;
      cmp_word();
      // sine-family cond one is undefined when out of range
      if (!care[9]) exp_w[9] = word[9];
      exp_w = nxt(exp_w);
      care = (cpl && ic == fsw_pkg::CLASS_TRIG && rest[12]) ? 16'hfdff : 16'hffff;
   endtask
   initial begin
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 12; i++) step(i, 1'b1);
      $display("directed classes done");
      for (int i = 0; i < 3000; i++) step(i, 1'b0);
      $display("random traffic done");
      test_done();
   end
   initial begin
      #100000;
      failures++;
      test_done();
   end
endmodule
`default_nettype wire
